//--- hw/io_remap_pkg.sv
// Package with offsets, field layouts and reset values of the remap registers
package io_remap_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] OFS_SERIAL_REMAP = 12'h000;
	localparam logic [11:0] OFS_MEMDBG_REMAP = 12'h004;
	localparam logic [31:0] RESET_VALUE      = 32'h0000_0000;
	// ****************************************
	// Writable bit masks
	// ****************************************
	localparam logic [31:0] MASK_SERIAL = 32'hFFFF_F0FF;
	localparam logic [31:0] MASK_MEMDBG = 32'h0F17_0300;
	// ****************************************
	// Field positions, serial register
	// ****************************************
	localparam int UART4_LSB  = 28;
	localparam int USART3_LSB = 24;
	localparam int USART2_LSB = 20;
	localparam int USART1_LSB = 16;
	localparam int SDIO2_LSB  = 12;
	localparam int CAN2_LSB   = 4;
	localparam int CAN1_LSB   = 0;
	// ****************************************
	// Field positions, memory/debug register
	// ****************************************
	localparam int NADV_BIT    = 27;
	localparam int EXTMEM_LSB  = 24;
	localparam int XTAL_BIT    = 20;
	localparam int DEBUG_LSB   = 16;
	localparam int ADC2_RG_BIT = 9;
	localparam int ADC2_PE_BIT = 8;
	// ****************************************
	// Select codes
	// ****************************************
	localparam logic [3:0] CODE_0 = 4'h0;
	localparam logic [3:0] CODE_1 = 4'h1;
	localparam logic [3:0] CODE_2 = 4'h2;
	localparam logic [3:0] CODE_3 = 4'h3;
	localparam logic [2:0] DBG_FULL   = 3'h0;
	localparam logic [2:0] DBG_NO_RST = 3'h1;
	localparam logic [2:0] DBG_SWD    = 3'h2;
	localparam logic [2:0] DBG_NONE   = 3'h4;
endpackage : io_remap_pkg

//--- hw/io_remap_regs_six_seven.sv
// Pin remap registers six and seven with APB slave and decoded selects
//
// What this block does
// - Bits 31:28 pick the UART4 pins: 0000 port C pair, 0010 port A pair, others unused.
// - Bits 27:24 route USART3 lines: 0000, 0001 and 0011 are three pin sets, others unused.
// - Bits 23:20 route USART2 signals: 0000 port A, 0001 port D, others unused.
// - Bits 19:16 route USART1 lines: 0000 port A pair, 0001 port B pair, others unused.
// - Bits 15:12 route SDIO2: even codes 0/2 give eight data lines, odd 1/3 four; low pair vs high pair moves clock/cmd.
// - Bits 7:4 route CAN2: 0000 one port B pair, 0001 another, others unused.
// - Bits 3:0 route CAN1: 00 port A, 10 port B, 11 port D, others unused.
// - Bit 27 of register seven set releases the memory address-valid strobe pin.
// - Bits 26:24 pick the external memory pin set, codes 0, 1, 2 valid.
// - Bit 20 set maps port D pins 0 and 1 onto the crystal pads.
// - Bits 18:16 set debug pins: 000 full, 001 frees reset pin, 010 serial-wire only, 100 all freed.
// - Bit 9 picks the ADC2 regular trigger: 0 interrupt line 11, 1 timer 8 trigger out.
// - Bit 8 picks the ADC2 preempted trigger: 0 interrupt line 15, 1 timer 8 channel 4.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module io_remap_regs_six_seven (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// UART and USART routing, one-hot per pin set, zero when unused
	output logic      [1:0]  uart4_pin_select,
	output logic      [2:0]  usart3_pin_select,
	output logic      [1:0]  usart2_pin_select,
	output logic      [1:0]  usart1_pin_select,
	// SDIO2 routing
	output logic             sdio2Enable,
	output logic             sdio2Wide,
	output logic             sdio2ClkCmdAlt,
	// CAN routing
	output logic      [1:0]  can2_pin_select,
	output logic      [2:0]  can1_pin_select,
	// External memory
	output logic             ext_mem_addr_valid_strobe,
	output logic      [2:0]  ext_mem_pin_select,
	// Crystal pads and debug port
	output logic             crystal_pad_gpio_map,
	output logic             debugJtagEnable,
	output logic             jtag_reset_pin,
	output logic             debugSwdEnable,
	// ADC2 trigger routing
	output logic             adc2_regular_trigger_select,
	output logic             adc2_preempt_trigger_select,
	output logic             adc2RegFromTimer8TrigOut,
	output logic             adc2PreFromTimer8Ch4
);
	// ****************************************
	// Bus decode
	// ****************************************
	logic        selSerial;
	logic        selMemDbg;
	logic        accessPhase;
	logic [31:0] serialWord;
	logic [31:0] memDbgWord;
	logic [31:0] nxt_prdata;
	logic        nxt_pslverr;
	logic        wrSerial;
	logic        wrMemDbg;

	// Selects four-bit field at a given offset
	function automatic logic [3:0] field4(input logic [31:0] w, input int lsb);
		field4 = 4'((w >> lsb) & 32'h0000_000F);
	endfunction : field4

	assign accessPhase = psel & penable;
	assign pready      = accessPhase;
	assign wrSerial    = accessPhase & pwrite & selSerial;
	assign wrMemDbg    = accessPhase & pwrite & selMemDbg;

	always_comb begin
		selSerial = 1'b0;
		selMemDbg = 1'b0;
		if (paddr == io_remap_pkg::OFS_SERIAL_REMAP) begin
			selSerial = 1'b1;
		end else if (paddr == io_remap_pkg::OFS_MEMDBG_REMAP) begin
			selMemDbg = 1'b1;
		end
	end

	// ****************************************
	// Register words
	// ****************************************
	// reserved bits masked
	remap_word_reg serialReg (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wrEn    (wrSerial),
		.wrData  (pwdata),
		.wrMask  (io_remap_pkg::MASK_SERIAL),
		.word_ff (serialWord)
	);

	remap_word_reg memDbgReg (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wrEn    (wrMemDbg),
		.wrData  (pwdata),
		.wrMask  (io_remap_pkg::MASK_MEMDBG),
		.word_ff (memDbgWord)
	);

	// ****************************************
	// Read data and error
	// ****************************************
	// readback of stored fields
	always_comb begin
		nxt_prdata  = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		if (selSerial) begin
			nxt_prdata = serialWord;
		end else if (selMemDbg) begin
			nxt_prdata = memDbgWord;
		end else begin
			nxt_pslverr = 1'b1;
		end
	end

	// Read data held in a flop; setup cycle loads it ready for the access cycle
	logic [31:0] rdata_ff;
	logic        err_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rdata_ff <= io_remap_pkg::RESET_VALUE;
		end else if (psel & ~penable & ~pwrite) begin
			rdata_ff <= nxt_prdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			err_ff <= 1'b0;
		end else if (psel & ~penable) begin
			err_ff <= nxt_pslverr;
		end
	end

	assign prdata  = rdata_ff;
	assign pslverr = accessPhase & err_ff;

	// ****************************************
	// Next register words
	// ****************************************
	// Selects decode the word due after this edge, so they move on the same edge as the register
	logic [31:0] nxt_serialWord;
	logic [31:0] nxt_memDbgWord;

	always_comb begin
		nxt_serialWord = serialWord;
		if (!rst_b) begin
			nxt_serialWord = io_remap_pkg::RESET_VALUE;
		end else if (wrSerial) begin
			nxt_serialWord = pwdata & io_remap_pkg::MASK_SERIAL;
		end
	end

	always_comb begin
		nxt_memDbgWord = memDbgWord;
		if (!rst_b) begin
			nxt_memDbgWord = io_remap_pkg::RESET_VALUE;
		end else if (wrMemDbg) begin
			nxt_memDbgWord = pwdata & io_remap_pkg::MASK_MEMDBG;
		end
	end

	// ****************************************
	// Serial field decode
	// ****************************************
	logic [3:0] fUart4;
	logic [3:0] fUsart3;
	logic [3:0] fUsart2;
	logic [3:0] fUsart1;
	logic [3:0] fSdio2;
	logic [3:0] fCan2;
	logic [3:0] fCan1;
	logic [1:0] nxt_uart4Sel;
	logic [2:0] nxt_usart3Sel;
	logic [1:0] nxt_usart2Sel;
	logic [1:0] nxt_usart1Sel;
	logic       nxt_sdio2Enable;
	logic       nxt_sdio2Wide;
	logic       nxt_sdio2ClkCmdAlt;
	logic [1:0] nxt_can2Sel;
	logic [2:0] nxt_can1Sel;
	assign fUart4  = field4(nxt_serialWord, io_remap_pkg::UART4_LSB);
	assign fUsart3 = field4(nxt_serialWord, io_remap_pkg::USART3_LSB);
	assign fUsart2 = field4(nxt_serialWord, io_remap_pkg::USART2_LSB);
	assign fUsart1 = field4(nxt_serialWord, io_remap_pkg::USART1_LSB);
	assign fSdio2  = field4(nxt_serialWord, io_remap_pkg::SDIO2_LSB);
	assign fCan2   = field4(nxt_serialWord, io_remap_pkg::CAN2_LSB);
	assign fCan1   = field4(nxt_serialWord, io_remap_pkg::CAN1_LSB);

	assign nxt_uart4Sel[0] = (fUart4 == io_remap_pkg::CODE_0);
	assign nxt_uart4Sel[1] = (fUart4 == io_remap_pkg::CODE_2);
	assign nxt_usart3Sel[0] = (fUsart3 == io_remap_pkg::CODE_0);
	assign nxt_usart3Sel[1] = (fUsart3 == io_remap_pkg::CODE_1);
	assign nxt_usart3Sel[2] = (fUsart3 == io_remap_pkg::CODE_3);
	assign nxt_usart2Sel[0] = (fUsart2 == io_remap_pkg::CODE_0);
	assign nxt_usart2Sel[1] = (fUsart2 == io_remap_pkg::CODE_1);
	assign nxt_usart1Sel[0] = (fUsart1 == io_remap_pkg::CODE_0);
	assign nxt_usart1Sel[1] = (fUsart1 == io_remap_pkg::CODE_1);
	assign nxt_sdio2Enable    = (fSdio2[3:2] == 2'h0);
	assign nxt_sdio2Wide      = nxt_sdio2Enable & ~fSdio2[0];
	assign nxt_sdio2ClkCmdAlt = nxt_sdio2Enable & fSdio2[1];
	assign nxt_can2Sel[0] = (fCan2 == io_remap_pkg::CODE_0);
	assign nxt_can2Sel[1] = (fCan2 == io_remap_pkg::CODE_1);
	assign nxt_can1Sel[0] = (fCan1 == io_remap_pkg::CODE_0);
	assign nxt_can1Sel[1] = (fCan1 == io_remap_pkg::CODE_2);
	assign nxt_can1Sel[2] = (fCan1 == io_remap_pkg::CODE_3);

	// Serial selects in flops, reset reaches them through the next word
	always_ff @(posedge clk_sys) begin
		uart4_pin_select  <= nxt_uart4Sel;
		usart3_pin_select <= nxt_usart3Sel;
		usart2_pin_select <= nxt_usart2Sel;
		usart1_pin_select <= nxt_usart1Sel;
		sdio2Enable       <= nxt_sdio2Enable;
		sdio2Wide         <= nxt_sdio2Wide;
		sdio2ClkCmdAlt    <= nxt_sdio2ClkCmdAlt;
		can2_pin_select   <= nxt_can2Sel;
		can1_pin_select   <= nxt_can1Sel;
	end

	// ****************************************
	// Memory, debug and ADC decode
	// ****************************************
	logic [2:0] fExtMem;
	logic [2:0] fDebug;
	logic       nxt_addrValidStrobe;
	logic [2:0] nxt_extMemSel;
	logic       nxt_crystalMap;
	logic       nxt_jtagEnable;
	logic       nxt_jtagReset;
	logic       nxt_swdEnable;
	logic       nxt_adc2RegSel;
	logic       nxt_adc2PreSel;
	assign fExtMem = nxt_memDbgWord[io_remap_pkg::EXTMEM_LSB +: 3];
	assign fDebug  = nxt_memDbgWord[io_remap_pkg::DEBUG_LSB +: 3];

	assign nxt_addrValidStrobe = ~nxt_memDbgWord[io_remap_pkg::NADV_BIT];
	// memory pin sets, unused routes nothing
	assign nxt_extMemSel[0] = (fExtMem == io_remap_pkg::CODE_0[2:0]);
	assign nxt_extMemSel[1] = (fExtMem == io_remap_pkg::CODE_1[2:0]);
	assign nxt_extMemSel[2] = (fExtMem == io_remap_pkg::CODE_2[2:0]);
	assign nxt_crystalMap = nxt_memDbgWord[io_remap_pkg::XTAL_BIT];

	// debug pin config, unlisted codes keep full debug
	always_comb begin
		nxt_jtagEnable = 1'b1;
		nxt_jtagReset  = 1'b1;
		nxt_swdEnable  = 1'b1;
		case (fDebug)
			io_remap_pkg::DBG_NO_RST: begin
				nxt_jtagReset = 1'b0;
			end
			io_remap_pkg::DBG_SWD: begin
				nxt_jtagEnable = 1'b0;
				nxt_jtagReset  = 1'b0;
			end
			io_remap_pkg::DBG_NONE: begin
				nxt_jtagEnable = 1'b0;
				nxt_jtagReset  = 1'b0;
				nxt_swdEnable  = 1'b0;
			end
			default: begin
				nxt_swdEnable = 1'b1;
			end
		endcase
	end

	assign nxt_adc2RegSel = nxt_memDbgWord[io_remap_pkg::ADC2_RG_BIT];
	assign nxt_adc2PreSel = nxt_memDbgWord[io_remap_pkg::ADC2_PE_BIT];

	// Memory, debug and ADC selects in flops, reset reaches them through the next word
	always_ff @(posedge clk_sys) begin
		ext_mem_addr_valid_strobe   <= nxt_addrValidStrobe;
		ext_mem_pin_select          <= nxt_extMemSel;
		crystal_pad_gpio_map        <= nxt_crystalMap;
		debugJtagEnable             <= nxt_jtagEnable;
		jtag_reset_pin              <= nxt_jtagReset;
		debugSwdEnable              <= nxt_swdEnable;
		adc2_regular_trigger_select <= nxt_adc2RegSel;
		adc2RegFromTimer8TrigOut    <= nxt_adc2RegSel;
		adc2_preempt_trigger_select <= nxt_adc2PreSel;
		adc2PreFromTimer8Ch4        <= nxt_adc2PreSel;
	end
endmodule : io_remap_regs_six_seven

//--- hw/remap_word_reg.sv
// One masked 32-bit register word with write enable
`timescale 1ns/1ps
module remap_word_reg (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Write side
	input  wire logic        wrEn,
	input  wire logic [31:0] wrData,
	input  wire logic [31:0] wrMask,
	// Stored value
	output logic      [31:0] word_ff
);
	// Reserved bits never store, so they always read zero
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			word_ff <= io_remap_pkg::RESET_VALUE;
		end else if (wrEn) begin
			word_ff <= wrData & wrMask;
		end
	end
endmodule : remap_word_reg

//--- verif/io_remap_properties.sv
// Checker for the remap register pair at the block's ports
`timescale 1ns/1ps
module io_remap_properties (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_b,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Selects
	input wire logic [1:0]  uart4_pin_select,
	input wire logic [2:0]  can1_pin_select,
	input wire logic [1:0]  can2_pin_select,
	input wire logic        ext_mem_addr_valid_strobe,
	input wire logic        crystal_pad_gpio_map,
	input wire logic        debugJtagEnable,
	input wire logic        jtag_reset_pin,
	input wire logic        debugSwdEnable,
	input wire logic        adc2_regular_trigger_select
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence wr6;
		psel && penable && pwrite && paddr == 12'h000;
	endsequence
	sequence wr7;
		psel && penable && pwrite && paddr == 12'h004;
	endsequence
	zero_wait_a: assert property (pready == (psel && penable)) else $error("pready off");
	addr_err_a: assert property (psel && penable && paddr != 12'h000 && paddr != 12'h004 |-> pslverr)
		else $error("no error on unmapped");
	uart4_sel_a: assert property (wr6 |=> uart4_pin_select ==
		{$past(pwdata[31:28]) == 4'h2, $past(pwdata[31:28]) == 4'h0}) else $error("uart4 select");
	can1_sel_a: assert property (wr6 |=> can1_pin_select ==
		{$past(pwdata[3:0]) == 4'h3, $past(pwdata[3:0]) == 4'h2, $past(pwdata[3:0]) == 4'h0})
		else $error("can1 select");
	strobe_rel_a: assert property (wr7 |=> ext_mem_addr_valid_strobe == !$past(pwdata[27]))
		else $error("strobe release");
	xtal_map_a: assert property (wr7 |=> crystal_pad_gpio_map == $past(pwdata[20])) else $error("xtal map");
	dbg_free_a: assert property (wr7 ##0 pwdata[18:16] == 3'h4 |=>
		!(debugJtagEnable || jtag_reset_pin || debugSwdEnable)) else $error("debug pins kept");
	adc_trig_a: assert property (wr7 |=> adc2_regular_trigger_select == $past(pwdata[9]))
		else $error("adc2 trigger");
	sel_hold_a: assert property (!(psel && penable && pwrite) |=> $stable(can2_pin_select))
		else $error("select moved");
endmodule : io_remap_properties

bind io_remap_regs_six_seven io_remap_properties u_props (
	.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.uart4_pin_select, .can1_pin_select, .can2_pin_select, .ext_mem_addr_valid_strobe,
	.crystal_pad_gpio_map, .debugJtagEnable, .jtag_reset_pin, .debugSwdEnable,
	.adc2_regular_trigger_select
);

//--- verif/io_remap_regs_six_seven_bench.sv
// Self-checking bench for the remap register pair
`timescale 1ns/1ps
module io_remap_regs_six_seven_bench;
	logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [1:0]  u4, u2, u1, c2;
	logic [2:0]  u3, c1, em;
	logic        sEn, sWid, sAlt, stb, xtl, jEn, jRst, swd, aRg, aPr, aRgT, aPrT;
	int          bad_count = 0;
	int          n_checks = 0;
	wire  [16:0] v6 = {u4, u3, u2, u1, sEn, sWid, sAlt, c2, c1};
	wire  [11:0] v7 = {stb, em, xtl, jEn, jRst, swd, aRg, aPr, aRgT, aPrT};
	io_remap_regs_six_seven uut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .uart4_pin_select(u4), .usart3_pin_select(u3),
		.usart2_pin_select(u2), .usart1_pin_select(u1), .sdio2Enable(sEn), .sdio2Wide(sWid),
		.sdio2ClkCmdAlt(sAlt), .can2_pin_select(c2), .can1_pin_select(c1),
		.ext_mem_addr_valid_strobe(stb), .ext_mem_pin_select(em), .crystal_pad_gpio_map(xtl),
		.debugJtagEnable(jEn), .jtag_reset_pin(jRst), .debugSwdEnable(swd),
		.adc2_regular_trigger_select(aRg), .adc2_preempt_trigger_select(aPr),
		.adc2RegFromTimer8TrigOut(aRgT), .adc2PreFromTimer8Ch4(aPrT));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Idle edge after release, so the next call never drives psel twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b1, a, d);
		apb(1'b0, a, 32'h0);
		chk("readback", d & m, rdat);
	endtask : wr_rd
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Far above the roughly 70 cycles the tests need
	initial begin
		#200000;
		bad_count++;
		finish_test;
	end
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		chk("reg6 sel", {2'h1, 3'h1, 2'h1, 2'h1, 3'h6, 2'h1, 3'h1}, v6);
		chk("reg7 sel", {1'h1, 3'h1, 1'h0, 3'h7, 4'h0}, v7);
		apb(1'b0, 12'h004, 32'h0);
		chk("reg7 read", 32'h0, rdat);
		$display("test reset done");
		wr_rd(12'h000, 32'h2311_3013, 32'hFFFF_F0FF);
		chk("reg6 sel", {2'h2, 3'h4, 2'h2, 2'h2, 3'h5, 2'h2, 3'h4}, v6);
		wr_rd(12'h000, 32'h0100_2002, 32'hFFFF_F0FF);
		chk("reg6 sel", {2'h1, 3'h2, 2'h1, 2'h1, 3'h7, 2'h1, 3'h2}, v6);
		wr_rd(12'h000, 32'hFFFF_F0FF, 32'hFFFF_F0FF);
		chk("reg6 sel", 32'h0, v6);
		$display("test serial done");
		wr_rd(12'h004, 32'h0F17_0300, 32'h0F17_0300);
		chk("reg7 sel", {1'h0, 3'h0, 1'h1, 3'h7, 4'hF}, v7);
		wr_rd(12'h004, 32'h0A04_0000, 32'h0F17_0300);
		chk("reg7 sel", {1'h0, 3'h4, 1'h0, 3'h0, 4'h0}, v7);
		wr_rd(12'h004, 32'h0111_0200, 32'h0F17_0300);
		chk("reg7 sel", {1'h1, 3'h2, 1'h1, 3'h5, 4'hA}, v7);
		wr_rd(12'h004, 32'h0002_0100, 32'h0F17_0300);
		chk("reg7 sel", {1'h1, 3'h1, 1'h0, 3'h1, 4'h5}, v7);
		$display("test memdbg done");
		apb(1'b1, 12'h008, 32'h0000_0000);
		chk("write error", 32'h1, rerr);
		chk("reg6 kept", 32'h0, v6);
		apb(1'b0, 12'hFFC, 32'h0);
		chk("read error", 32'h1, rerr);
		chk("read data", 32'h0, rdat);
		$display("test unmapped done");
		finish_test;
	end
endmodule : io_remap_regs_six_seven_bench
